// >>> pkg/wdp_pkg.sv
// constants and decode helpers for the wait, decode and write-protect unit
package wdp_pkg;
  // chip select indices
  localparam int SEL_ROM = 0;
  localparam int SEL_EEP = 1;
  localparam int SEL_PER1 = 2;
  localparam int SEL_PER2 = 3;
  localparam int SEL_SRAM = 4;
  localparam int NSEL = 5;

  // memory map: a region hits when (addr & mask) == base
  localparam logic [15:0] ROM_BASE = 16'h8000;
  localparam logic [15:0] ROM_MASK = 16'h8000;
  localparam logic [15:0] EEP_BASE = 16'h2000;
  localparam logic [15:0] EEP_MASK = 16'he000;
  localparam logic [15:0] SRAM_BASE = 16'h0000;
  localparam logic [15:0] SRAM_MASK = 16'he000;
  localparam logic [15:0] PER1_BASE = 16'h4000;
  localparam logic [15:0] PER1_MASK = 16'hff00;
  localparam logic [15:0] PER2_BASE = 16'h4100;
  localparam logic [15:0] PER2_MASK = 16'hff00;

  // protection control windows, low three address bits pick the select
  localparam logic [15:0] PROT_SET_BASE = 16'h7e00;
  localparam logic [15:0] PROT_CLR_BASE = 16'h7e10;
  localparam logic [15:0] PROT_CTL_MASK = 16'hfff8;

  // wait states per select
  localparam logic [1:0] WAIT_ROM = 2'h0;
  localparam logic [1:0] WAIT_EEP = 2'h1;
  localparam logic [1:0] WAIT_PER1 = 2'h1;
  localparam logic [1:0] WAIT_PER2 = 2'h2;
  localparam logic [1:0] WAIT_SRAM = 2'h0;

  // reset and timing values
  localparam logic [4:0] PROT_RESET = 5'h1f;
  localparam logic [1:0] ERR_CLKS = 2'h2;

  // one-hot select for an address, all zero for invalid space
  function automatic logic [NSEL-1:0] wdp_decode(input logic [15:0] a);
    logic [NSEL-1:0] s;
    s = '0;
    s[SEL_ROM] = ((a & ROM_MASK) == ROM_BASE);
    s[SEL_EEP] = ((a & EEP_MASK) == EEP_BASE);
    s[SEL_SRAM] = ((a & SRAM_MASK) == SRAM_BASE);
    s[SEL_PER1] = ((a & PER1_MASK) == PER1_BASE);
    s[SEL_PER2] = ((a & PER2_MASK) == PER2_BASE);
    return s;
  endfunction : wdp_decode

  // wait count for a one-hot select
  function automatic logic [1:0] wdp_waits(input logic [NSEL-1:0] s);
    logic [1:0] w;
    w = 2'h0;
    if (s[SEL_EEP]) w = WAIT_EEP;
    if (s[SEL_PER1]) w = WAIT_PER1;
    if (s[SEL_PER2]) w = WAIT_PER2;
    if (s[SEL_ROM]) w = WAIT_ROM;
    if (s[SEL_SRAM]) w = WAIT_SRAM;
    return w;
  endfunction : wdp_waits
endpackage : wdp_pkg

// >>> pkg/wdp_wait_if.sv
// link between the access control and the wait-state generator
`timescale 1ns/1ps
interface wdp_wait_if;
  logic arm;
  logic [1:0] wait_cnt;
  logic t2_pulse;
  logic strobe_n;
  modport gen (input arm, input wait_cnt, output t2_pulse, output strobe_n);
  modport ctl (output arm, output wait_cnt, input t2_pulse, input strobe_n);
endinterface : wdp_wait_if

// >>> hdl/wdp_wait_gen.sv
// wait-state generator: armed by the latch pulse, strobes from the second clock state
`timescale 1ns/1ps
module wdp_wait_gen (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // control side
  wdp_wait_if.gen w
);
  typedef enum logic [1:0] {WS_IDLE, WS_ARMED, WS_HOLD} wdp_ws_t;

  wdp_ws_t state_reg, state_next;
  logic [1:0] cnt_reg, cnt_next;
  logic strobe_n_reg, strobe_n_next;

  // next state; a new latch pulse always rearms, even mid-strobe
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    strobe_n_next = strobe_n_reg;
    case (state_reg)
      WS_IDLE: begin
        if (w.arm) begin
          state_next = WS_ARMED;
          cnt_next = w.wait_cnt;
        end
      end
      WS_ARMED: begin
        if (w.arm) begin
          cnt_next = w.wait_cnt;
        end else if (cnt_reg != 2'h0) begin
          state_next = WS_HOLD;
          strobe_n_next = 1'b0;
        end else begin
          state_next = WS_IDLE;
        end
      end
      WS_HOLD: begin
        if (w.arm) begin
          state_next = WS_ARMED;
          cnt_next = w.wait_cnt;
          strobe_n_next = 1'b1;
        end else if (cnt_reg == 2'h1) begin
          state_next = WS_IDLE;
          strobe_n_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 2'h1;
        end
      end
      default: begin
        state_next = WS_IDLE;
        strobe_n_next = 1'b1;
      end
    endcase
  end

  // registers only
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= WS_IDLE;
      cnt_reg <= 2'h0;
      strobe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      strobe_n_reg <= strobe_n_next;
    end
  end

  // first clock after the latch pulse ends marks the second bus state
  assign w.t2_pulse = (state_reg == WS_ARMED) && !w.arm;
  assign w.strobe_n = strobe_n_reg;
endmodule : wdp_wait_gen

// >>> hdl/wdp_top.sv
// wait-state generator, address decoder and write protector for an 8-bit cpu bus
`timescale 1ns/1ps
module wdp_top #(
  parameter bit ERR_ACTIVE_HIGH = 1'b0
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // processor bus
  input wire logic [15:0] addr_in,
  input wire logic ale_in,
  input wire logic transfer_direction_status_in,
  input wire logic cycle_status_line_in,
  // chip selects, active low
  output logic [4:0] cs_n_out,
  // wait line, open drain
  output logic ready_out,
  output logic ready_oe_n_out,
  // write error line, released when idle
  output logic err_out,
  output logic err_oe_n_out
);
  wdp_wait_if wif ();

  logic [15:0] addr_reg, addr_next;
  logic write_reg, write_next;
  logic [4:0] prot_reg, prot_next;
  logic [4:0] cs_n_reg, cs_n_next;
  logic [1:0] err_cnt_reg, err_cnt_next;
  logic [4:0] sel;
  logic valid;
  logic [2:0] ctl_idx;
  logic ctl_set;
  logic ctl_clr;
  logic bad_write;

  // the wait generator sees the select of the address on the bus during the latch pulse
  // armed by latch pulse
  assign wif.arm = ale_in;
  assign wif.wait_cnt = wdp_pkg::wdp_waits(wdp_pkg::wdp_decode(addr_in));

  wdp_wait_gen u_wait (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .w(wif.gen)
  );

  // decode of the latched cycle
  // five region decode
  assign sel = wdp_pkg::wdp_decode(addr_reg);
  assign valid = |sel;
  assign ctl_idx = addr_reg[2:0];
  assign ctl_set = !write_reg && (ctl_idx < 3'h5)
    && ((addr_reg & wdp_pkg::PROT_CTL_MASK) == wdp_pkg::PROT_SET_BASE);
  assign ctl_clr = !write_reg && (ctl_idx < 3'h5)
    && ((addr_reg & wdp_pkg::PROT_CTL_MASK) == wdp_pkg::PROT_CLR_BASE);
  assign bad_write = write_reg && (!valid || ((sel & prot_reg) != 5'h00));

  // address and status are caught while the latch pulse is high
  always_comb begin
    addr_next = addr_reg;
    write_next = write_reg;
    if (ale_in) begin
      addr_next = addr_in;
      write_next = transfer_direction_status_in && !cycle_status_line_in;
    end
  end

  // protection and error timing run off the second-state pulse
  always_comb begin
    prot_next = prot_reg;
    err_cnt_next = (err_cnt_reg != 2'h0) ? err_cnt_reg - 2'h1 : 2'h0;
    // control windows lie in invalid space, so a write there protects everything
    if (wif.t2_pulse) begin
      if (write_reg && !valid) begin
        prot_next = 5'h1f;
      end else if (ctl_set) begin
        prot_next[ctl_idx] = 1'b1;
      end else if (ctl_clr) begin
        prot_next[ctl_idx] = 1'b0;
      end
      if (bad_write) begin
        err_cnt_next = wdp_pkg::ERR_CLKS;
      end
    end
  end

  // selects follow the latched cycle; writes to protected selects never reach the part
  // reads still reach a protected part; only writes are held off
  always_comb begin
    // every select gated by protection and write status
    cs_n_next = ~(wdp_pkg::wdp_decode(addr_next) & ~({5{write_next}} & prot_next));
  end

  // registers only; protection resets on so a power-up glitch cannot write the eeprom
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_reg <= 16'h0000;
      write_reg <= 1'b0;
      prot_reg <= wdp_pkg::PROT_RESET;
      cs_n_reg <= 5'h1f;
      err_cnt_reg <= 2'h0;
    end else begin
      addr_reg <= addr_next;
      write_reg <= write_next;
      prot_reg <= prot_next;
      cs_n_reg <= cs_n_next;
      err_cnt_reg <= err_cnt_next;
    end
  end

  // outputs; both open lines only ever pull, so with the error line low-going they can share a wired-or net
  assign cs_n_out = cs_n_reg;
  assign ready_out = 1'b0;
  assign ready_oe_n_out = wif.strobe_n;
  // a high-going build needs a pull-down on the error line instead of a pull-up
  // polarity chosen at build
  assign err_out = ERR_ACTIVE_HIGH;
  assign err_oe_n_out = (err_cnt_reg == 2'h0);

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  // checks
  chk_prot_reset_on: assert property ($rose(rst_n_in) |-> prot_reg == 5'h1f)
    else $error("protection not on after reset");
  chk_rom_no_wait: assert property (
    (ale_in ##1 !ale_in && wdp_pkg::wdp_decode(addr_reg) == 5'h01) |=> ready_oe_n_out [*3])
    else $error("wait driven for rom");
  chk_per2_two_wait: assert property (
    (ale_in ##1 (!ale_in && sel[wdp_pkg::SEL_PER2])) |=> !ready_oe_n_out [*2] ##1 ready_oe_n_out)
    else $error("peripheral two wait not two clocks");
  chk_eep_one_wait: assert property (
    (ale_in ##1 (!ale_in && sel[wdp_pkg::SEL_EEP])) |=> !ready_oe_n_out ##1 ready_oe_n_out)
    else $error("eeprom wait not one clock");
  chk_strobe_after_t2: assert property ($fell(ready_oe_n_out) |-> $past(wif.t2_pulse))
    else $error("strobe not at second state");
  chk_err_two_clk: assert property (
    (wif.t2_pulse && bad_write) |=> !err_oe_n_out [*2] ##1 err_oe_n_out)
    else $error("error pulse not two clocks");
  chk_err_cause: assert property (
    $fell(err_oe_n_out) |-> $past(bad_write) && $past(wif.t2_pulse))
    else $error("error without bad write");
  chk_invalid_protects: assert property (
    (wif.t2_pulse && write_reg && !valid) |=> prot_reg == 5'h1f)
    else $error("invalid write did not protect");
  chk_ctl_clear: assert property ((wif.t2_pulse && ctl_clr) |=> !prot_reg[$past(ctl_idx)])
    else $error("protection not cleared");
  chk_eep_gated: assert property (
    (!ale_in && write_reg && prot_reg[wdp_pkg::SEL_EEP]) |=> cs_n_out[wdp_pkg::SEL_EEP])
    else $error("protected eeprom selected for write");
  chk_cs_onehot: assert property ($onehot0(~cs_n_out))
    else $error("more than one select active");
  chk_err_level: assert property (err_out == ERR_ACTIVE_HIGH)
    else $error("error polarity wrong");
  chk_wait_count: assert property (
    (ale_in && ((addr_in & wdp_pkg::PER2_MASK) == wdp_pkg::PER2_BASE))
    |-> wif.wait_cnt == wdp_pkg::WAIT_PER2)
    else $error("wait count wrong for peripheral two");

  // further wait-state checks
  chk_sram_no_wait: assert property (
    (ale_in ##1 (!ale_in && sel[wdp_pkg::SEL_SRAM])) |=> ready_oe_n_out [*3])
    else $error("wait driven for sram");
  chk_per1_one_wait: assert property (
    (ale_in ##1 (!ale_in && sel[wdp_pkg::SEL_PER1])) |=> !ready_oe_n_out ##1 ready_oe_n_out)
    else $error("peripheral one wait not one clock");
  chk_invalid_no_wait: assert property (
    (ale_in ##1 (!ale_in && !valid)) |=> ready_oe_n_out [*3])
    else $error("wait driven for invalid space");
  chk_strobe_max_len: assert property (
    $fell(ready_oe_n_out) |-> ##[1:2] ready_oe_n_out)
    else $error("strobe longer than two clocks");
  chk_t2_single: assert property (wif.t2_pulse |=> !wif.t2_pulse)
    else $error("second-state pulse longer than one clock");

  // protection and select checks
  chk_ctl_set: assert property ((wif.t2_pulse && ctl_set) |=> prot_reg[$past(ctl_idx)])
    else $error("protection not set");
  chk_prot_stable: assert property (!wif.t2_pulse |=> $stable(prot_reg))
    else $error("protection changed outside second state");
  chk_eep_read_sel: assert property (
    (!ale_in && !write_reg && sel[wdp_pkg::SEL_EEP]) |=> !cs_n_out[wdp_pkg::SEL_EEP])
    else $error("eeprom read not selected");
  chk_cs_write_ok: assert property (
    (!ale_in && write_reg && valid && ((sel & prot_reg) == 5'h00)) |=> cs_n_out == ~sel)
    else $error("unprotected write not selected");
  chk_write_latch: assert property (
    (ale_in && transfer_direction_status_in && !cycle_status_line_in) |=> write_reg)
    else $error("write status not latched");
  chk_idle_after_reset: assert property (
    $rose(rst_n_in) |-> cs_n_out == 5'h1f && ready_oe_n_out && err_oe_n_out)
    else $error("outputs not idle after reset");

  // main scenarios
  cov_eep_write_ok: cover property (wif.t2_pulse && write_reg && sel[wdp_pkg::SEL_EEP] && !bad_write);
  cov_ctl_set: cover property (wif.t2_pulse && ctl_set);
  cov_bad_write: cover property (wif.t2_pulse && bad_write);
  cov_unprotect: cover property (wif.t2_pulse && ctl_clr);
  cov_per2_cycle: cover property (wif.t2_pulse && sel[wdp_pkg::SEL_PER2]);
endmodule : wdp_top

// >>> verification/wdp_cpu_model.sv
// behavioural processor bus master: latch pulse, address and write status
`timescale 1ns/1ps
module wdp_cpu_model (
  // clock
  input wire logic clk_sys_in,
  // processor bus
  output logic [15:0] addr_out,
  output logic ale_out,
  output logic dir_out,
  output logic status_out
);
  initial begin
    addr_out = 16'h0000;
    ale_out = 1'b0;
    dir_out = 1'b0;
    status_out = 1'b1;
  end

  // control reads issued like any other cycle
  // bus turns round after the latch clock, so stale values are inverted
  task automatic bus_cycle(input logic [15:0] a, input logic wr, input int gap);
    @(negedge clk_sys_in);
    addr_out = a;
    dir_out = wr;
    status_out = ~wr;
    ale_out = 1'b1;
    @(negedge clk_sys_in);
    ale_out = 1'b0;
    addr_out = ~a;
    dir_out = ~wr;
    status_out = wr;
    repeat (gap) @(negedge clk_sys_in);
  endtask : bus_cycle
endmodule : wdp_cpu_model

// >>> verification/wait_decode_write_protect_test.sv
// self-checking bench for the wait, decode and write-protect unit
`timescale 1ns/1ps
module wait_decode_write_protect_test;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] addr_in;
  logic ale_in;
  logic dir_in;
  logic status_in;
  logic [4:0] cs_n_out;
  logic ready_out;
  logic ready_oe_n_out;
  logic err_out;
  logic err_oe_n_out;
  logic [4:0] prot;
  logic [31:0] r;
  int failures = 0;
  int comparisons = 0;
  int seed = 32'ha0a1;
  int cyc = 0;
  int wt[5] = '{0, 1, 1, 2, 0};
  logic [15:0] base[5] = '{16'h8000, 16'h2000, 16'h4000, 16'h4100, 16'h0000};

  wdp_cpu_model cpu (.clk_sys_in(clk_sys_in), .addr_out(addr_in), .ale_out(ale_in),
    .dir_out(dir_in), .status_out(status_in));
  wdp_top DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .ale_in(ale_in), .transfer_direction_status_in(dir_in),
    .cycle_status_line_in(status_in), .cs_n_out(cs_n_out), .ready_out(ready_out),
    .ready_oe_n_out(ready_oe_n_out), .err_out(err_out), .err_oe_n_out(err_oe_n_out));

  // 20 MHz clock
  always #25 clk_sys_in = ~clk_sys_in;

  // hang guard, generous against roughly eight hundred expected cycles
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc > 4000) begin
      failures++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // reference decode, -1 for invalid space
  function automatic int sel_of(input logic [15:0] a);
    if (a < 16'h2000) return 4;
    if (a < 16'h4000) return 1;
    if (a < 16'h4100) return 2;
    if (a < 16'h4200) return 3;
    if (a >= 16'h8000) return 0;
    return -1;
  endfunction : sel_of

  // one bus cycle against the reference model
  task automatic run_cycle(input logic [15:0] a, input logic wr);
    int s;
    int nw;
    int ne;
    logic [4:0] ecs;
    s = sel_of(a);
    ecs = 5'h1f;
    if (s >= 0 && !(wr && prot[s])) ecs[s] = 1'b0;
    nw = 0;
    ne = 0;
    fork
      cpu.bus_cycle(a, wr, 7 + ({$random(seed)} % 3));
      begin
        repeat (3) @(negedge clk_sys_in);
        check({3'h0, cs_n_out}, {3'h0, ecs});
        // pulses only count when the driven level is the active one
        // strobe and error both start in the clock seen here, so sample before moving on
        repeat (6) begin
          nw += (ready_oe_n_out === 1'b0 && ready_out === 1'b0);
          ne += (err_oe_n_out === 1'b0 && err_out === 1'b0);
          @(negedge clk_sys_in);
        end
      end
    join
    check(8'(nw), 8'((s >= 0) ? wt[s] : 0));
    check(8'(ne), 8'((wr && (s < 0 || prot[s])) ? 2 : 0));
    if (wr && s < 0) prot = 5'h1f;
    if (!wr && (a & wdp_pkg::PROT_CTL_MASK) == wdp_pkg::PROT_SET_BASE && a[2:0] < 5)
      prot[a[2:0]] = 1'b1;
    if (!wr && (a & wdp_pkg::PROT_CTL_MASK) == wdp_pkg::PROT_CLR_BASE && a[2:0] < 5)
      prot[a[2:0]] = 1'b0;
  endtask : run_cycle

  initial begin
    prot = 5'h1f;
    repeat (6) @(posedge clk_sys_in);
    check({3'h0, cs_n_out}, 8'h1f);
    @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    run_cycle(16'h2000, 1'b1);
    $display("test power-up protection done");
    for (int i = 0; i < 5; i++) run_cycle(16'h7e10 + 16'(i), 1'b0);
    foreach (base[i]) begin
      run_cycle(base[i], 1'b0);
      run_cycle(base[i] + 16'h0010, 1'b1);
    end
    $display("test decode and waits done");
    run_cycle(16'h7e03, 1'b0);
    run_cycle(16'h4120, 1'b1);
    run_cycle(16'h6000, 1'b1);
    run_cycle(16'h0005, 1'b1);
    $display("test protect control done");
    repeat (60) begin
      r = $random(seed);
      if (r[20]) run_cycle(16'h7e00 | {11'h0, r[4], 2'h0, r[1:0]}, 1'b0);
      else run_cycle(r[15:0], r[16]);
    end
    $display("test random traffic done");
    complete_run();
  end
endmodule : wait_decode_write_protect_test
